// >>> pkg/scmc_pkg.sv
// Constants and types for the system clock and mode controller
package scmc_pkg;
    localparam logic [7:0] OSC_MODE_CTRL_ADDR = 8'hca;
    localparam int         HALT_BIT           = 1;
    localparam int         SLOW_BIT           = 2;
    localparam int         MODE_LSB           = 3;
    localparam logic [7:0] OSC_MODE_RESET     = 8'h00;
    localparam logic [7:0] OSC_MODE_WMASK     = 8'h1e;
    localparam logic [1:0] MODE_NORMAL        = 2'h0;
    localparam logic [1:0] MODE_SLEEP         = 2'h1;
    localparam logic [1:0] MODE_GREEN         = 2'h2;
    localparam int         WARM_LONG_CYC      = 2048;
    localparam int         WARM_SHORT_CYC     = 32;
    localparam int         CFG_SLOW_CYC       = 2048;
    localparam int         SLOW_DIV           = 4;
    localparam int         FILTER_MIN_LOG     = 2;
    localparam int         DIV_MAX_LOG        = 7;
    typedef enum logic [2:0] {
        OPT_INTERNAL_ONLY, OPT_INTERNAL_RTC, OPT_EXT_RC,
        OPT_WATCH_CRYSTAL, OPT_FAST_CRYSTAL, OPT_MID_CRYSTAL
    } scmc_osc_opt_t;
    typedef enum logic [2:0] {
        ST_CONFIG, ST_WARM, ST_RUN, ST_SLEEP, ST_GREEN
    } scmc_state_t;
endpackage

// >>> hdl/scmc_clock_mode_ctrl.sv
// System clock source, instruction rate and operating mode controller
//
// Function
// - Normal mode instruction rate is high clock divided by 1 to 128 option.
// - Slow mode instruction rate is low oscillator divided by four.
// - Noise filter limits the divider to four through 128.
// - Internal-only option: internal fast RC, both oscillator pins are GPIO.
// - RTC option: internal fast RC clocks system, pins drive watch crystal.
// - External RC option uses input pin only, output pin stays GPIO.
// - Low oscillator stops only in sleep, or green with watch crystal, no dog.
// - Low oscillator clocks the watchdog and the slow mode system clock.
// - Bit 1 set stops the high oscillator; low oscillator keeps running.
// - Bit 2 selects high clock when clear, low clock when set.
// - Bits 4:3 encode normal, sleep, green; 11 reserved.
// - Halt bit stops the option's high oscillator or fast RC; crystal options keep crystal drive on.
// - RTC option: halt gates both fast RC and crystal drive, in green as well.
// - Any reset waits 2048 high clock cycles before running.
// - Sleep wake waits 2048 cycles for crystals, 32 for RC sources.
// - Power-on first spends 2048 low oscillator cycles configuring.
// - Wake from sleep clears the sleep request bit.
// - Slow mode leaves the high oscillator running until halt is set.
// - Green returns to its previous mode; sleep wakes into normal.
`timescale 1ns/10ps
`default_nettype none
module scmc_clock_mode_ctrl
    import scmc_pkg::*;
#(
    parameter scmc_osc_opt_t OSC_OPTION   = OPT_INTERNAL_ONLY,
    parameter int            DIV_LOG      = 2,
    parameter bit            NOISE_FILTER = 1'b0,
    parameter int            WARM_LONG    = WARM_LONG_CYC,
    parameter int            CFG_SLOW     = CFG_SLOW_CYC
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrStb,
    input  wire logic       regRdStb,
    output logic      [7:0] regRdData,
    input  wire logic       highTick,
    input  wire logic       slowTick,
    input  wire logic       wakeEvent,
    input  wire logic       watchdogEnable,
    output logic            highOscEnable,
    output logic            fastRcEnable,
    output logic            slowOscEnable,
    output logic            crystalDriveEnable,
    output logic            oscInPinIsGpio,
    output logic            oscOutPinIsGpio,
    output logic            cpuRun,
    output logic            cpuTick,
    output logic            watchdogTick,
    output logic            slowModeActive
);
    ////////////////////////////////////////////////////////////////////////
    // Option decode
    localparam bit IS_INTERNAL = (OSC_OPTION == OPT_INTERNAL_ONLY) ||
                                 (OSC_OPTION == OPT_INTERNAL_RTC);
    localparam bit IS_RTC      = (OSC_OPTION == OPT_INTERNAL_RTC);
    localparam bit IS_CRYSTAL  = (OSC_OPTION == OPT_WATCH_CRYSTAL) ||
                                 (OSC_OPTION == OPT_FAST_CRYSTAL) ||
                                 (OSC_OPTION == OPT_MID_CRYSTAL);
    // Divider clamped by filter option
    localparam int DIV_EFF = (NOISE_FILTER && DIV_LOG < FILTER_MIN_LOG) ? FILTER_MIN_LOG :
                             (DIV_LOG > DIV_MAX_LOG) ? DIV_MAX_LOG : DIV_LOG;

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers for pin and foreign-domain inputs
    logic [1:0] hiSync_r, loSync_r, wkSync_r, wdSync_r;
    logic       hiPrev_r, loPrev_r;
    logic       hiPulse, loPulse;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hiSync_r <= 2'h0;
            loSync_r <= 2'h0;
            wkSync_r <= 2'h0;
            wdSync_r <= 2'h0;
            hiPrev_r <= 1'b0;
            loPrev_r <= 1'b0;
        end else begin
            hiSync_r <= {hiSync_r[0], highTick};
            loSync_r <= {loSync_r[0], slowTick};
            wkSync_r <= {wkSync_r[0], wakeEvent};
            wdSync_r <= {wdSync_r[0], watchdogEnable};
            hiPrev_r <= hiSync_r[1];
            loPrev_r <= loSync_r[1];
        end
    end
    assign hiPulse = hiSync_r[1] & ~hiPrev_r;
    assign loPulse = loSync_r[1] & ~loPrev_r;

    ////////////////////////////////////////////////////////////////////////
    // Register and mode state
    scmc_state_t  state_r, state_nxt;
    logic         halt_r, halt_nxt;
    logic         slow_r, slow_nxt;
    logic [1:0]   mode_r, mode_nxt;
    logic [11:0]  cnt_r, cnt_nxt;
    logic [11:0]  warmLen_r, warmLen_nxt;
    logic [6:0]   div_r, div_nxt;
    logic [1:0]   sdiv_r, sdiv_nxt;
    logic         tick_r, tick_nxt;
    logic         wdt_r, wdt_nxt;
    logic [7:0]   rd_r, rd_nxt;
    logic         wrHit;
    logic [1:0]   modeReq;

    assign wrHit   = regWrStb && (regAddr == OSC_MODE_CTRL_ADDR);
    assign modeReq = regWrData[MODE_LSB +: 2];

    always_comb begin
        state_nxt   = state_r;
        halt_nxt    = halt_r;
        slow_nxt    = slow_r;
        mode_nxt    = mode_r;
        cnt_nxt     = cnt_r;
        warmLen_nxt = warmLen_r;
        div_nxt     = div_r;
        sdiv_nxt    = sdiv_r;
        tick_nxt    = 1'b0;
        wdt_nxt     = loPulse;
        rd_nxt      = 8'h00;
        if (regRdStb) begin
            if (regAddr == OSC_MODE_CTRL_ADDR) begin
                rd_nxt = {3'h0, mode_r, slow_r, halt_r, 1'b0} & OSC_MODE_WMASK;
            end else begin
                rd_nxt = 8'h00;
            end
        end
        if (wrHit && state_r == ST_RUN) begin
            halt_nxt = regWrData[HALT_BIT];
            slow_nxt = regWrData[SLOW_BIT];
            mode_nxt = (modeReq == MODE_SLEEP || modeReq == MODE_GREEN) ?
                       modeReq : MODE_NORMAL;
        end
        case (state_r)
            ST_CONFIG: begin
                if (loPulse) begin
                    cnt_nxt = cnt_r + 12'h001;
                    if (cnt_r == 12'(CFG_SLOW - 1)) begin
                        cnt_nxt   = 12'h000;
                        state_nxt = ST_WARM;
                    end
                end
            end
            ST_WARM: begin
                if (hiPulse) begin
                    cnt_nxt = cnt_r + 12'h001;
                    if (cnt_r == warmLen_r) begin
                        cnt_nxt   = 12'h000;
                        state_nxt = ST_RUN;
                    end
                end
            end
            ST_RUN: begin
                if (wrHit && modeReq == MODE_SLEEP) begin
                    state_nxt = ST_SLEEP;
                end else if (wrHit && modeReq == MODE_GREEN) begin
                    state_nxt = ST_GREEN;
                end
            end
            ST_SLEEP: begin
                if (wkSync_r[1]) begin
                    mode_nxt    = MODE_NORMAL;
                    slow_nxt    = 1'b0;
                    halt_nxt    = 1'b0;
                    warmLen_nxt = IS_CRYSTAL ? 12'(WARM_LONG - 1) :
                                  12'(WARM_SHORT_CYC - 1);
                    cnt_nxt     = 12'h000;
                    state_nxt   = ST_WARM;
                end
            end
            ST_GREEN: begin
                if (wkSync_r[1]) begin
                    mode_nxt  = MODE_NORMAL;
                    state_nxt = ST_RUN;
                end
            end
            default: state_nxt = ST_CONFIG;
        endcase
        // Instruction-rate dividers run only while executing
        if (state_r == ST_RUN) begin
            if (slow_r) begin
                if (loPulse) begin
                    sdiv_nxt = sdiv_r + 2'h1;
                    tick_nxt = (sdiv_r == 2'(SLOW_DIV - 1));
                end
            end else if (hiPulse && !halt_r) begin
                div_nxt  = (div_r == 7'((1 << DIV_EFF) - 1)) ? 7'h00 : div_r + 7'h01;
                tick_nxt = (div_r == 7'((1 << DIV_EFF) - 1));
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r   <= ST_CONFIG;
            halt_r    <= OSC_MODE_RESET[HALT_BIT];
            slow_r    <= OSC_MODE_RESET[SLOW_BIT];
            mode_r    <= OSC_MODE_RESET[MODE_LSB +: 2];
            cnt_r     <= 12'h000;
            warmLen_r <= 12'(WARM_LONG - 1);
            div_r     <= 7'h00;
            sdiv_r    <= 2'h0;
            tick_r    <= 1'b0;
            wdt_r     <= 1'b0;
            rd_r      <= 8'h00;
        end else begin
            state_r   <= state_nxt;
            halt_r    <= halt_nxt;
            slow_r    <= slow_nxt;
            mode_r    <= mode_nxt;
            cnt_r     <= cnt_nxt;
            warmLen_r <= warmLen_nxt;
            div_r     <= div_nxt;
            sdiv_r    <= sdiv_nxt;
            tick_r    <= tick_nxt;
            wdt_r     <= wdt_nxt;
            rd_r      <= rd_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Oscillator enables and pin modes
    logic sleeping, greenNow;
    assign sleeping  = (state_r == ST_SLEEP);
    assign greenNow  = (state_r == ST_GREEN);
    assign regRdData = rd_r;
    assign highOscEnable = !sleeping && !(halt_r && !(IS_RTC && greenNow)) &&
                           !IS_INTERNAL;
    assign fastRcEnable  = IS_INTERNAL && !sleeping && !halt_r;
    assign slowOscEnable = !sleeping && !(greenNow && OSC_OPTION == OPT_WATCH_CRYSTAL &&
                           !wdSync_r[1]);
    assign crystalDriveEnable = !sleeping && (IS_CRYSTAL || (IS_RTC && !halt_r));
    assign oscInPinIsGpio  = (OSC_OPTION == OPT_INTERNAL_ONLY);
    assign oscOutPinIsGpio = (OSC_OPTION == OPT_INTERNAL_ONLY) ||
                             (OSC_OPTION == OPT_EXT_RC);
    assign cpuRun         = (state_r == ST_RUN);
    assign cpuTick        = tick_r;
    assign watchdogTick   = wdt_r;
    assign slowModeActive = slow_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    // Mode transitions and warm-up
    no_tick_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r != ST_RUN) |=> !tick_r) else $error("tick outside run");
    sleep_clears_a: assert property (@(posedge clk) disable iff (!rst_n)
        (sleeping && wkSync_r[1]) |=> (mode_r == MODE_NORMAL && !slow_r &&
        state_r == ST_WARM)) else $error("sleep wake wrong");
    green_return_a: assert property (@(posedge clk) disable iff (!rst_n)
        (greenNow && wkSync_r[1]) |=> (state_r == ST_RUN && $stable(slow_r)))
        else $error("green wake wrong");
    cfg_to_warm_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == ST_CONFIG && loPulse && cnt_r == 12'(CFG_SLOW - 1)) |=>
        (state_r == ST_WARM && cnt_r == 12'h000)) else $error("config end");
    warm_exit_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == ST_WARM && hiPulse && cnt_r == warmLen_r) |=>
        (cpuRun && cnt_r == 12'h000)) else $error("warm exit missed");
    warm_len_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == ST_WARM ##1 state_r == ST_RUN) |-> $past(cnt_r) == warmLen_r)
        else $error("warm count wrong");
    wake_len_a: assert property (@(posedge clk) disable iff (!rst_n)
        (sleeping && wkSync_r[1]) |=> (warmLen_r == (IS_CRYSTAL ?
        12'(WARM_LONG - 1) : 12'(WARM_SHORT_CYC - 1)))) else $error("wake length");
    write_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wrHit && (state_r == ST_CONFIG || state_r == ST_WARM)) |=>
        $stable({mode_r, slow_r, halt_r})) else $error("write before run");
    reserved_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
        mode_r != 2'h3) else $error("reserved mode stored");
    // Rates and oscillators
    halt_stops_a: assert property (@(posedge clk) disable iff (!rst_n)
        (halt_r && !greenNow) |-> (!highOscEnable && !fastRcEnable)) else $error("halt");
    fast_rate_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cpuRun && !slow_r && hiPulse && !halt_r && div_r == 7'((1 << DIV_EFF) - 1)) |=>
        tick_r) else $error("fast tick missing");
    slow_rate_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cpuRun && slow_r && $past(slow_r) && tick_r) |->
        ##1 !(tick_r && slow_r) ##1 !(tick_r && slow_r) ##1 !(tick_r && slow_r))
        else $error("slow rate");
    wdog_tick_a: assert property (@(posedge clk) disable iff (!rst_n)
        loPulse |=> watchdogTick) else $error("watchdog tick missing");
    sleep_osc_a: assert property (@(posedge clk) disable iff (!rst_n)
        sleeping |-> !slowOscEnable) else $error("slow osc in sleep");
    run_osc_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!sleeping && !greenNow) |-> slowOscEnable) else $error("slow osc stopped");

    // Scenario covers
    run_c: cover property (@(posedge clk) disable iff (!rst_n)
        state_r == ST_WARM ##1 state_r == ST_RUN);
    sleep_c: cover property (@(posedge clk) disable iff (!rst_n)
        sleeping ##1 state_r == ST_WARM);
    green_c: cover property (@(posedge clk) disable iff (!rst_n)
        greenNow ##1 state_r == ST_RUN);
    slow_c: cover property (@(posedge clk) disable iff (!rst_n)
        cpuRun && slow_r && tick_r);
    halt_c: cover property (@(posedge clk) disable iff (!rst_n)
        cpuRun && halt_r);
endmodule
`default_nettype wire

// >>> bench/tb.sv
// Self-checking bench for the system clock and mode controller
`timescale 1ns/10ps
`default_nettype none
module tb;
    import scmc_pkg::*;
    localparam int WARM = 16;
    localparam int CFG  = 16;
    localparam int DIVL = 2;
    logic       clk, rst_n, regWrStb, regRdStb, highTick, slowTick, wakeEvent, watchdogEnable;
    logic [7:0] regAddr, regWrData, regRdData, rdVal, wrVal, expReg;
    logic       highOscEnable, fastRcEnable, slowOscEnable, crystalDriveEnable;
    logic       oscInPinIsGpio, oscOutPinIsGpio, cpuRun, cpuTick, watchdogTick, slowModeActive;
    int         fails, nChecks, cyc, hEdges, sEdges, cpuTicks, wdTicks, h0, seed;

    scmc_clock_mode_ctrl #(.OSC_OPTION(OPT_INTERNAL_ONLY), .DIV_LOG(DIVL), .NOISE_FILTER(1'b0),
        .WARM_LONG(WARM), .CFG_SLOW(CFG)) DUT (
        .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
        .highTick(highTick), .slowTick(slowTick), .wakeEvent(wakeEvent),
        .watchdogEnable(watchdogEnable), .highOscEnable(highOscEnable),
        .fastRcEnable(fastRcEnable), .slowOscEnable(slowOscEnable),
        .crystalDriveEnable(crystalDriveEnable), .oscInPinIsGpio(oscInPinIsGpio),
        .oscOutPinIsGpio(oscOutPinIsGpio), .cpuRun(cpuRun), .cpuTick(cpuTick),
        .watchdogTick(watchdogTick), .slowModeActive(slowModeActive));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Oscillators stand still while the design disables them
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc % 2 == 1 && (highOscEnable === 1'b1 || fastRcEnable === 1'b1)) begin
            highTick <= ~highTick;
            if (!highTick) hEdges <= hEdges + 1;
        end
        if (cyc % 8 == 7 && slowOscEnable === 1'b1) begin
            slowTick <= ~slowTick;
            if (!slowTick) sEdges <= sEdges + 1;
        end
        if (cpuTick === 1'b1) cpuTicks <= cpuTicks + 1;
        if (watchdogTick === 1'b1) wdTicks <= wdTicks + 1;
        if (cyc > 20000) begin
            fails++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        nChecks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_near(input int got, input int exp, input int tol);
        nChecks++;
        if (got < exp - tol || got > exp + tol) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddr   <= a;
        regWrData <= d;
        regWrStb  <= 1'b1;
        @(posedge clk);
        regWrStb  <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        regAddr  <= a;
        regRdStb <= 1'b1;
        @(posedge clk);
        regRdStb <= 1'b0;
        #1 d = regRdData;
        @(posedge clk);
    endtask

    task automatic wait_run();
        int n;
        n = 0;
        while (cpuRun !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        #1 cmp(cpuRun, 1'b1);
        @(posedge clk);
    endtask

    task automatic rate(input bit slow, input int edges, input int perTick);
        int e0;
        int s0;
        int c0;
        int w0;
        e0 = slow ? sEdges : hEdges;
        s0 = sEdges;
        c0 = cpuTicks;
        w0 = wdTicks;
        while ((slow ? sEdges : hEdges) - e0 < edges) @(posedge clk);
        cmp_near(cpuTicks - c0, edges / perTick, 1);
        cmp_near(wdTicks - w0, sEdges - s0, 1);
    endtask

    task automatic sleep_wake(input logic [7:0] cmd, input logic [7:0] expAfter, input bit lowOn);
        wr(OSC_MODE_CTRL_ADDR, cmd);
        #1 cmp(cpuRun, 1'b0);
        cmp(slowOscEnable, lowOn);
        wakeEvent <= 1'b1;
        h0 = hEdges;
        wait_run();
        wakeEvent <= 1'b0;
        rd(OSC_MODE_CTRL_ADDR, rdVal);
        cmp(rdVal, expAfter);
    endtask

    task automatic print_verdict();
        $display("checks=%0d fails=%0d", nChecks, fails);
        if (fails == 0 && nChecks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, regWrStb, regRdStb, highTick, slowTick, wakeEvent} = 6'h00;
        {regAddr, regWrData} = 16'h0000;
        watchdogEnable = 1'b1;
        {fails, nChecks, cyc, hEdges, sEdges, cpuTicks, wdTicks} = '0;
        seed = $urandom(32'h33f5);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        wr(OSC_MODE_CTRL_ADDR, 8'h04);
        #1 cmp(cpuRun, 1'b0);
        wait_run();
        cmp_near(sEdges, CFG + WARM / 4, 2);
        cmp({oscInPinIsGpio, oscOutPinIsGpio, crystalDriveEnable, fastRcEnable}, 8'h0d);
        rd(OSC_MODE_CTRL_ADDR, rdVal);
        cmp(rdVal, OSC_MODE_RESET);
        rd(8'h55, rdVal);
        cmp(rdVal, 8'h00);
        for (int i = 0; i < 8; i++) begin
            wrVal = 8'($urandom);
            wrVal[4] = wrVal[3];
            wr(OSC_MODE_CTRL_ADDR, wrVal);
            rd(OSC_MODE_CTRL_ADDR, rdVal);
            expReg = wrVal & OSC_MODE_WMASK;
            if (expReg[4:3] == 2'h3) expReg[4:3] = MODE_NORMAL;
            cmp(rdVal, expReg);
            cmp(fastRcEnable, !expReg[HALT_BIT]);
            cmp(highOscEnable, 1'b0);
            cmp(slowModeActive, expReg[SLOW_BIT]);
            cmp(slowOscEnable, 1'b1);
        end
        wr(OSC_MODE_CTRL_ADDR, 8'h00);
        rate(1'b0, 64, 1 << DIVL);
        wr(OSC_MODE_CTRL_ADDR, 8'h04);
        #1 cmp(fastRcEnable, 1'b1);
        rate(1'b1, 32, SLOW_DIV);
        sleep_wake(8'h14, 8'h04, 1'b1);
        cmp(slowModeActive, 1'b1);
        sleep_wake(8'h0e, 8'h00, 1'b0);
        cmp_near(hEdges - h0, WARM_SHORT_CYC, 3);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1 cmp(cpuRun, 1'b0);
        rst_n <= 1'b1;
        wait_run();
        rd(OSC_MODE_CTRL_ADDR, rdVal);
        cmp(rdVal, OSC_MODE_RESET);
        print_verdict();
    end
endmodule
`default_nettype wire
